// ---- logic/antenna_supervisor_pkg.sv ----
package antenna_supervisor_pkg;

   // ---------------------------------------------------------------
   // Register map (word addresses on the plain register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] CTRL_OFF    = 4'h0;
   localparam logic [3:0] STATUS_OFF  = 4'h1;
   localparam logic [3:0] IRQ_OFF     = 4'h2;
   localparam logic [3:0] MASK_OFF    = 4'h3;
   localparam logic [3:0] REPORT_OFF  = 4'h4;

   // ---------------------------------------------------------------
   // Control field positions
   // ---------------------------------------------------------------
   localparam int CTRL_SUPPLY_BIT = 0;
   localparam int CTRL_SHORT_BIT  = 1;
   localparam int CTRL_OPEN_BIT   = 2;
   localparam int CTRL_PDOS_BIT   = 3;
   localparam int CTRL_RETRY_BIT  = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;

   // ---------------------------------------------------------------
   // Feature flags in the supervisor report
   // ---------------------------------------------------------------
   localparam int FLAG_AC   = 0;
   localparam int FLAG_SD   = 1;
   localparam int FLAG_OD   = 2;
   localparam int FLAG_PDOS = 3;
   localparam int FLAG_SR   = 4;

   // ---------------------------------------------------------------
   // Report kinds and antenna status codes
   // ---------------------------------------------------------------
   localparam logic [1:0] KIND_FEATURES = 2'h1;
   localparam logic [1:0] KIND_STATUS   = 2'h2;

   typedef enum logic [2:0]
   {
      ANT_INIT  = 3'h0,
      ANT_OK    = 3'h1,
      ANT_SHORT = 3'h2,
      ANT_OPEN  = 3'h3
   } ant_status_t;

   // ---------------------------------------------------------------
   // Interrupt bits
   // ---------------------------------------------------------------
   localparam int IRQ_REPORT_BIT = 0;
   localparam int IRQ_SHORT_BIT  = 1;
   localparam int IRQ_OPEN_BIT   = 2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ          = 250;
   localparam int RETRY_TIME_MS    = 1000;
   localparam int RETRY_CYCLES     = RETRY_TIME_MS * CLK_MHZ * 1000;
   localparam int SYNC_STAGES      = 3;

endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync
   import antenna_supervisor_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic reset_level,
   // Pin and result
   input  wire logic pin_in,
   output logic      level_out
);

   logic [SYNC_STAGES-1:0] stage_reg;

   // Shift chain; first stage feeds only the second
   // Reset to the pin's idle pull level so no false change follows reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         stage_reg <= {SYNC_STAGES{reset_level}};
      else
         stage_reg <= {stage_reg[SYNC_STAGES-2:0], pin_in};
   end

   // Accept a change only when the last two stages agree
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         level_out <= reset_level;
      else if (stage_reg[1] == stage_reg[2])
         level_out <= stage_reg[2];
   end

endmodule

// ---- logic/antenna_supervisor.sv ----
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Contract
// - No status reports without supply control enable
// - Power cut high removes power, low powers
// - Short check: pull-up, low means short
// - Short without power-down: report, keep powered; code cuts power on any short with supply control (AC) and retry (SR) set, even with PDoS clear
// - Short status sticky until retry/cycle/toggle
// - Auto retry: cut power, report off, SHORT
// - After timeout, retest; no short reports OK
// - Open check: pull-up, low reports OPEN
// - Open check: high or floating reports OK
// - Start-up: features, then INIT, then status
// - Feature flags AC SD OD PDoS SR
// - Enabled supervisor reports OK after power-up
module antenna_supervisor
   import antenna_supervisor_pkg::*;
#(
   parameter int RETRY_COUNT = RETRY_CYCLES
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [31:0]      reg_rdata,
   // Antenna pins
   input  wire logic        short_sense_n,
   output logic             short_pullup_en,
   input  wire logic        antenna_presence_sense,
   output logic             presence_pullup_en,
   output logic             antenna_power_cut,
   // Report stream
   output logic             report_valid,
   output logic [1:0]       report_kind,
   output logic [4:0]       report_flags,
   output logic [2:0]       report_status,
   output logic             report_power_on,
   // Interrupt
   output logic             irq
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      ST_IDLE     = 4'b0001,
      ST_FEATURES = 4'b0010,
      ST_INIT     = 4'b0100,
      ST_RUN      = 4'b1000
   } seq_t;

   seq_t        seq_reg;
   logic [4:0]  ctrl_reg;
   logic        short_sync;
   logic        presence_sync;
   logic        short_latched_reg;
   logic        cut_reg;
   logic [31:0] retry_cnt_reg;
   logic [2:0]  settle_reg;
   ant_status_t status_reg;
   ant_status_t status_next;
   logic [2:0]  irq_stat_reg;
   logic [2:0]  irq_mask_reg;
   logic [2:0]  irq_set;
   logic        short_now;
   logic        open_now;
   logic        supply_en;
   logic        short_en;
   logic        retry_en;
   logic        short_en_prev_reg;
   logic        emit;
   logic        emit_reg;

   assign supply_en = ctrl_reg[CTRL_SUPPLY_BIT];
   assign short_en  = ctrl_reg[CTRL_SHORT_BIT];
   assign retry_en  = ctrl_reg[CTRL_RETRY_BIT];

   // ---------------------------------------------------------------
   // Pin input synchronisers
   // ---------------------------------------------------------------
   // three-stage synchronising
   pin_sync short_sync_i
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .reset_level (1'b1),
      .pin_in      (short_sense_n),
      .level_out   (short_sync)
   );

   pin_sync presence_sync_i
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .reset_level (1'b1),
      .pin_in      (antenna_presence_sense),
      .level_out   (presence_sync)
   );

   assign short_pullup_en    = short_en;
   assign presence_pullup_en = ctrl_reg[CTRL_OPEN_BIT];

   // low means short; ignored while power is cut for retry
   assign short_now = short_en && !short_sync && !cut_reg;
   assign open_now  = ctrl_reg[CTRL_OPEN_BIT] && !presence_sync;

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctrl_reg <= CTRL_RESET;
      else if (reg_write && reg_addr == CTRL_OFF)
         ctrl_reg <= reg_wdata[4:0];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         short_en_prev_reg <= 1'b0;
      else
         short_en_prev_reg <= short_en;
   end

   // ---------------------------------------------------------------
   // Sticky short and power-cut retry
   // ---------------------------------------------------------------
   // sticky short status; cleared by retry, reset or disable
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         short_latched_reg <= 1'b0;
      else if (short_now)
         short_latched_reg <= 1'b1;
      else if (!short_en)
         short_latched_reg <= 1'b0;
      else if (settle_reg == 3'h1 && !cut_reg)
         short_latched_reg <= 1'b0;
   end

   // cut power on short with retry enabled
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cut_reg <= 1'b0;
      else if (!supply_en || !retry_en || !short_en)
         cut_reg <= 1'b0;
      else if (short_now)
         cut_reg <= 1'b1;
      else if (cut_reg && retry_cnt_reg == 32'h0000_0000)
         cut_reg <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         retry_cnt_reg <= 32'h0000_0000;
      else if (short_now && retry_en)
         retry_cnt_reg <= 32'(RETRY_COUNT - 1);
      else if (cut_reg && retry_cnt_reg != 32'h0000_0000)
         retry_cnt_reg <= retry_cnt_reg - 32'h0000_0001;
   end

   // retest waits for fresh sense
   // A stale high level in the synchroniser would otherwise report OK too early
   always_ff @(posedge clk)
   begin
      if (sys_rst || !short_en)
         settle_reg <= 3'h0;
      else if (cut_reg && retry_cnt_reg == 32'h0000_0000 && supply_en && retry_en)
         settle_reg <= 3'(SYNC_STAGES + 2); // Sync latency plus one
      else if (settle_reg != 3'h0)
         settle_reg <= settle_reg - 3'h1;
   end

   // power cut output; low while powered
   assign antenna_power_cut = supply_en && cut_reg;

   // ---------------------------------------------------------------
   // Resolved status
   // ---------------------------------------------------------------
   // OK unless short or open
   always_comb
   begin
      if (short_latched_reg || short_now)
         status_next = ANT_SHORT;
      else if (open_now)
         status_next = ANT_OPEN;
      else
         status_next = ANT_OK;
   end

   // ---------------------------------------------------------------
   // Start-up sequence and report stream
   // ---------------------------------------------------------------
   // features, INIT, then resolved status
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         seq_reg <= ST_IDLE;
      else if (!supply_en)
         seq_reg <= ST_IDLE;
      else
      begin
         unique case (seq_reg)
            ST_IDLE:     seq_reg <= ST_FEATURES;
            ST_FEATURES: seq_reg <= ST_INIT;
            ST_INIT:     seq_reg <= ST_RUN;
            ST_RUN:      seq_reg <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         status_reg <= ANT_INIT;
      else if (seq_reg != ST_RUN)
         status_reg <= ANT_INIT;
      else
         status_reg <= status_next;
   end

   // emit only with supply control on; change or re-enable
   assign emit = supply_en && (seq_reg == ST_FEATURES || seq_reg == ST_INIT ||
                (seq_reg == ST_RUN && (status_reg != status_next ||
                 status_reg == ANT_INIT ||
                 (short_en && !short_en_prev_reg))));

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         emit_reg        <= 1'b0;
         report_kind     <= 2'h0;
         report_flags    <= 5'h00;
         report_status   <= ANT_INIT;
         report_power_on <= 1'b0;
      end
      else
      begin
         emit_reg <= emit;
         if (emit)
         begin
            report_kind <= (seq_reg == ST_FEATURES) ? KIND_FEATURES : KIND_STATUS;
            report_flags    <= ctrl_reg;
            report_status   <= (seq_reg == ST_RUN) ? status_next : ANT_INIT;
            report_power_on <= !(cut_reg || (short_now && retry_en));
         end
      end
   end

   assign report_valid = emit_reg;

   // ---------------------------------------------------------------
   // Interrupts: set wins over write-one-to-clear
   // ---------------------------------------------------------------
   assign irq_set = {emit && status_next == ANT_OPEN && seq_reg == ST_RUN,
                     emit && status_next == ANT_SHORT && seq_reg == ST_RUN,
                     emit};

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_stat_reg <= 3'h0;
      else if (reg_write && reg_addr == IRQ_OFF)
         irq_stat_reg <= (irq_stat_reg & ~reg_wdata[2:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         irq_mask_reg <= 3'h0;
      else if (reg_write && reg_addr == MASK_OFF)
         irq_mask_reg <= reg_wdata[2:0];
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ---------------------------------------------------------------
   // Register read, data one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0000_0000;
      else if (reg_read)
      begin
         unique case (reg_addr)
            CTRL_OFF:   reg_rdata <= {27'h0, ctrl_reg};
            STATUS_OFF: reg_rdata <= {25'h0, short_latched_reg, !short_sync,
                                      presence_sync, cut_reg, status_reg};
            IRQ_OFF:    reg_rdata <= {29'h0, irq_stat_reg};
            MASK_OFF:   reg_rdata <= {29'h0, irq_mask_reg};
            REPORT_OFF: reg_rdata <= {21'h0, report_power_on, report_status,
                                      report_flags, report_kind};
            default:    reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // no reports when disabled
   silent_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      !supply_en |=> !report_valid) else $error("report while disabled");
   // power cut only with supply control
   cut_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      antenna_power_cut |-> supply_en) else $error("cut without enable");
   keep_power_a: assert property (@(posedge clk) disable iff (sys_rst)
      !retry_en |=> !cut_reg) else $error("cut without retry");
   // short status stays without clear cause
   short_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
      short_latched_reg && short_en && !cut_reg && settle_reg != 3'h1 |=> short_latched_reg)
      else $error("short status dropped");
   // cut follows a short under retry
   short_cut_a: assert property (@(posedge clk) disable iff (sys_rst)
      short_now && retry_en && supply_en && !reg_write |=> antenna_power_cut)
      else $error("no cut on short");
   retry_end_a: assert property (@(posedge clk) disable iff (sys_rst)
      cut_reg && retry_cnt_reg == 32'h0 && supply_en && retry_en && short_en
      |=> !cut_reg) else $error("no retest after timeout");
   // no OK before the retest reading
   retest_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      settle_reg != 3'h0 |-> status_next == ANT_SHORT) else $error("OK before retest");
   pullup_a: assert property (@(posedge clk) disable iff (sys_rst)
      short_pullup_en == short_en) else $error("pull-up mismatch");
   sequence startup_s;
      seq_reg == ST_FEATURES && supply_en ##1 seq_reg == ST_INIT;
   endsequence
   startup_a: assert property (@(posedge clk) disable iff (sys_rst)
      startup_s |-> report_valid && report_kind == KIND_FEATURES)
      else $error("start-up order wrong");
   retry_load_a: assert property (@(posedge clk) disable iff (sys_rst)
      short_now && retry_en |=> retry_cnt_reg == 32'(RETRY_COUNT - 1))
      else $error("timeout not restarted");

endmodule

// ---- test/antenna_model.sv ----
`timescale 1ns/10ps
// Antenna switch and sense circuit as seen from the receiver pins
module antenna_model
(
   // Clock
   input  wire logic clk,
   // Receiver side
   input  wire logic short_pullup_en,
   input  wire logic presence_pullup_en,
   input  wire logic antenna_power_cut,
   // Scenario controls
   input  wire logic shorted,
   input  wire logic absent,
   // Sense lines
   output logic      short_sense_n,
   output logic      antenna_presence_sense
);
   logic flip = 1'b0;

   // Undriven line without pull-up wanders; toggling keeps the design from trusting it
   always @(posedge clk)
   begin
      flip <= ~flip;
   end

   // short pulls low
   // No current flows through a short once the supply is cut
   assign short_sense_n = (shorted && !antenna_power_cut) ? 1'b0 :
                          (short_pullup_en ? 1'b1 : flip);

   assign antenna_presence_sense = absent ? 1'b0 : (presence_pullup_en ? 1'b1 : flip);
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import antenna_supervisor_pkg::*;
   logic        clk, sys_rst, reg_write, reg_read, shorted, absent;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic        short_sense_n, short_pullup_en, antenna_presence_sense;
   logic        presence_pullup_en, antenna_power_cut, report_valid;
   logic        report_power_on, irq, irq_a;
   logic [1:0]  report_kind;
   logic [4:0]  report_flags;
   logic [2:0]  report_status;
   logic [10:0] e;
   logic [10:0] exp_q[$];
   int          errors = 0, n_checks = 0, cycles = 0, k;

   // ---------------------------------------------------------------
   // Clock, design and antenna circuit
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   antenna_supervisor #(.RETRY_COUNT(20)) i_antenna_supervisor
   (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .short_sense_n(short_sense_n), .short_pullup_en(short_pullup_en),
      .antenna_presence_sense(antenna_presence_sense),
      .presence_pullup_en(presence_pullup_en), .antenna_power_cut(antenna_power_cut),
      .report_valid(report_valid), .report_kind(report_kind),
      .report_flags(report_flags), .report_status(report_status),
      .report_power_on(report_power_on), .irq(irq)
   );

   antenna_model i_antenna_model
   (
      .clk(clk), .short_pullup_en(short_pullup_en),
      .presence_pullup_en(presence_pullup_en), .antenna_power_cut(antenna_power_cut),
      .shorted(shorted), .absent(absent), .short_sense_n(short_sense_n),
      .antenna_presence_sense(antenna_presence_sense)
   );

   // ---------------------------------------------------------------
   // Checking and reporting
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, ex, got);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // A hang is cut well after the longest scenario
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         results();
      end
   end

   // Oldest noted report against each one the design emits
   // Every report must have been noted first
   always @(posedge clk)
   begin
      if (report_valid === 1'b1)
      begin
         if (exp_q.size() != 0)
         begin
            e = exp_q.pop_front();
            chk("report_kind", {30'h0, e[10:9]}, {30'h0, report_kind});
            if (e[10:9] == KIND_FEATURES)
               chk("report_flags", {27'h0, e[8:4]}, {27'h0, report_flags});
            else
               chk("report_status", {29'h0, e[3:1]}, {29'h0, report_status});
            if (e[10:9] == KIND_STATUS && e[3:1] != ANT_INIT)
               chk("report_power_on", {31'h0, e[0]}, {31'h0, report_power_on});
         end
         else
            chk("unexpected_report", 32'h0, 32'h1);
      end
   end

   // ---------------------------------------------------------------
   // Bus and scenario tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input string name, input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] ex);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
      chk(name, ex, v & m);
   endtask

   task automatic exp_rep(input logic [1:0] kd, input logic [4:0] f, input logic [2:0] s,
                          input logic p);
      exp_q.push_back({kd, f, s, p});
   endtask

   task automatic drain();
      for (k = 0; k < 300 && exp_q.size() != 0; k++)
         @(posedge clk);
      chk("pending_reports", 32'h0, exp_q.size());
   endtask

   task automatic wcut(input logic lvl, input int lim);
      for (k = 0; k < lim && antenna_power_cut !== lvl; k++)
         @(posedge clk);
      #1 chk("antenna_power_cut", {31'h0, lvl}, {31'h0, antenna_power_cut});
   endtask

   // Fresh enable gives features, then INIT, then the resolved state
   task automatic startup(input logic [4:0] cfg);
      wr(CTRL_OFF, 32'h0);
      exp_rep(KIND_FEATURES, cfg, 3'h0, 1'b0);
      exp_rep(KIND_STATUS, 5'h00, ANT_INIT, 1'b0);
      exp_rep(KIND_STATUS, 5'h00, ANT_OK, 1'b1);
      wr(CTRL_OFF, {27'h0, cfg});
      drain();
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(75));
      sys_rst = 1'b1;
      {reg_write, reg_read, shorted, absent} = 4'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk("ctrl_reset", CTRL_OFF, 32'h1F, 32'h0);
      wr(4'hF, $urandom());
      rdchk("unmapped_read", 4'hF, 32'hFFFFFFFF, 32'h0);
      wr(CTRL_OFF, 32'h06);
      shorted <= 1'b1;
      absent <= 1'b1;
      repeat (30) @(posedge clk);
      #1 chk("short_pullup_en", 32'h1, {31'h0, short_pullup_en});
      chk("presence_pullup_en", 32'h1, {31'h0, presence_pullup_en});
      chk("cut_without_supply", 32'h0, {31'h0, antenna_power_cut});
      shorted <= 1'b0;
      absent <= 1'b0;
      repeat (10) @(posedge clk);
      startup(5'h01);
      chk("pullups_off", 32'h0, {30'h0, short_pullup_en, presence_pullup_en});
      startup(5'h03);
      exp_rep(KIND_STATUS, 5'h00, ANT_SHORT, 1'b1);
      shorted <= 1'b1;
      repeat (40) @(posedge clk);
      #1 chk("cut_on_plain_short", 32'h0, {31'h0, antenna_power_cut});
      shorted <= 1'b0;
      drain();
      repeat (20) @(posedge clk);
      rdchk("sticky_short", STATUS_OFF, 32'h7, {29'h0, ANT_SHORT});
      // Interrupt raised, masked either way, cleared
      rdchk("irq_short", IRQ_OFF, 32'h2, 32'h2);
      wr(MASK_OFF, 32'h0);
      repeat (2) @(posedge clk);
      #1 irq_a = irq;
      wr(MASK_OFF, 32'h7);
      repeat (2) @(posedge clk);
      #1 chk("irq_mask", 32'h1, {31'h0, irq_a ^ irq});
      wr(IRQ_OFF, 32'h7);
      rdchk("irq_clear", IRQ_OFF, 32'h7, 32'h0);
      chk("irq_low", 32'h0, {31'h0, irq});
      // short check off and on clears status; both steps report OK
      exp_rep(KIND_STATUS, 5'h00, ANT_OK, 1'b1);
      exp_rep(KIND_STATUS, 5'h00, ANT_OK, 1'b1);
      wr(CTRL_OFF, 32'h01);
      wr(CTRL_OFF, 32'h03);
      drain();
      rdchk("status_after_toggle", STATUS_OFF, 32'h7, {29'h0, ANT_OK});
      // cut, retest into a short, retest clean
      startup(5'h1B);
      exp_rep(KIND_STATUS, 5'h00, ANT_SHORT, 1'b0);
      shorted <= 1'b1;
      wcut(1'b1, 40);
      wcut(1'b0, 60);
      wcut(1'b1, 20);
      shorted <= 1'b0;
      exp_rep(KIND_STATUS, 5'h00, ANT_OK, 1'b1);
      wcut(1'b0, 60);
      drain();
      startup(5'h1F);
      exp_rep(KIND_STATUS, 5'h00, ANT_OPEN, 1'b1);
      absent <= 1'b1;
      drain();
      rdchk("irq_open", IRQ_OFF, 32'h4, 32'h4);
      exp_rep(KIND_STATUS, 5'h00, ANT_OK, 1'b1);
      absent <= 1'b0;
      drain();
      results();
   end
endmodule
